/* File: decim_a_defs.vh */
// register offsets, field positions, reset values and timing counts for the chain a decimator
`ifndef DECIM_A_DEFS_VH
`define DECIM_A_DEFS_VH
`define REG_DELAY_FIRST    8'h7A
`define REG_CHAIN_A        8'h7B
`define REG_DUAL_PP        8'h79
`define BIT_FIRST_EN       6
`define BIT_DELAY_REC_EN   5
`define BIT_DUAL_PP_EN     7
`define RST_DELAY_FIRST    8'h00
`define RST_CHAIN_A        8'h00
`define RST_DUAL_PP        8'h00
`define DELAY_REC_CYCLES   59
`define DATA_W             16
`define MODE_SINGLE        2'h0
`define MODE_DUAL          2'h1
`endif

/* File: decim_chain_a.v */
// chain a half-band decimation cascade with fractional delay recovery and registers
`timescale 1ns/1ps
`include "decim_a_defs.vh"
module decim_chain_a
(
    // clock and reset
    input  wire                 core_clk,
    input  wire                 reset_n,
    // register port
    input  wire [7:0]           reg_addr,
    input  wire [7:0]           reg_wdata,
    input  wire                 reg_wr,
    input  wire                 reg_rd,
    output reg  [7:0]           reg_rdata_ff,
    // channel mode from the converter core
    input  wire [1:0]           chan_mode,
    // sample stream in
    input  wire                 in_valid,
    input  wire [`DATA_W-1:0]   in_data,
    output reg                  in_ready_ff,
    // decimated stream out
    output reg                  out_valid_ff,
    output reg  [`DATA_W-1:0]   out_data_ff,
    input  wire                 out_ready,
    // status
    output reg  [3:0]           stage_count_ff
);
    reg [7:0] delay_first_ff;   // delay recovery and first stage control
    reg [7:0] chain_a_ff;       // stage setting bits 8:1
    reg [7:0] dual_pp_ff;       // dual channel post processing control
    reg [1:0] mode_s1_ff;       // mode synchroniser stage one
    reg [1:0] mode_ff;          // synchronised mode
    reg [8:0] avg_cnt_ff;       // input samples gathered this output
    reg [`DATA_W+8:0] acc_ff;   // running sum of gathered samples
    reg [`DATA_W-1:0] buf_data_ff [0:1]; // two entry skid buffer
    reg [1:0] buf_cnt_ff;       // buffer occupancy
    reg       buf_wp_ff;
    reg       buf_rp_ff;

    wire [8:0] setting = {chain_a_ff, delay_first_ff[`BIT_FIRST_EN]};
    wire mode_ok = (mode_ff == `MODE_SINGLE) || (mode_ff == `MODE_DUAL);
    wire is_dual = (mode_ff == `MODE_DUAL);

    // count contiguous ones from the start bit; a gap ends the cascade
    reg [3:0] nxt_stages;
    reg       run;
    integer   j;
    always @*
    begin
        nxt_stages = 4'h0;
        run        = 1'b1;
        for (j = 0; j < 9; j = j + 1)
        begin
            if (is_dual && j == 0)
                run = 1'b1;                                  // first stage forced off in dual
            else if (run && setting[j])
                nxt_stages = nxt_stages + 4'h1;
            else
                run = 1'b0;
        end
        if (!mode_ok)
            nxt_stages = 4'h0;
        if (is_dual && nxt_stages > 4'h8)
            nxt_stages = 4'h8;                               // 256 in dual
    end

    wire delay_en = mode_ok && delay_first_ff[`BIT_DELAY_REC_EN];
    wire [8:0] need = (9'h001 << stage_count_ff) - 9'h001;

    // register writes; mode sampled through two flops as it comes from the core pins
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            delay_first_ff <= `RST_DELAY_FIRST;
            chain_a_ff     <= `RST_CHAIN_A;
            dual_pp_ff     <= `RST_DUAL_PP;
            reg_rdata_ff   <= 8'h00;
            mode_s1_ff     <= 2'h0;
            mode_ff        <= 2'h0;
            stage_count_ff <= 4'h0;
        end
        else
        begin
            mode_s1_ff     <= chan_mode;
            mode_ff        <= mode_s1_ff;
            // dual mode needs the post processing enable, else the chain stays off
            stage_count_ff <= (is_dual && !dual_pp_ff[`BIT_DUAL_PP_EN]) ? 4'h0 : nxt_stages;
            if (reg_wr)
            begin
                // factory bits are stored as written; software keeps them
                case (reg_addr)
                    `REG_DELAY_FIRST: delay_first_ff <= reg_wdata;
                    `REG_CHAIN_A:   chain_a_ff   <= reg_wdata;
                    `REG_DUAL_PP:   dual_pp_ff   <= reg_wdata;
                    default:        delay_first_ff <= delay_first_ff;
                endcase
            end
            // read data valid only in the cycle after the strobe; unmapped reads zero
            if (reg_rd)
            begin
                case (reg_addr)
                    `REG_DELAY_FIRST: reg_rdata_ff <= delay_first_ff;
                    `REG_CHAIN_A:   reg_rdata_ff <= chain_a_ff;
                    `REG_DUAL_PP:   reg_rdata_ff <= dual_pp_ff;
                    default:        reg_rdata_ff <= 8'h00;
                endcase
            end
            else
                reg_rdata_ff <= 8'h00;
        end
    end

    // boxcar stand-in for the half-band cascade: one sum per 2^n inputs, halving rate per stage
    wire take = in_valid && in_ready_ff;
    // group sum is wide enough for 512 signed samples; only the low word of the mean is kept
    wire [`DATA_W+8:0] grp_sum  = acc_ff + {{9{in_data[`DATA_W-1]}}, in_data}; // sum including this sample
    wire [`DATA_W+8:0] grp_mean = grp_sum >> stage_count_ff;                   // divide by 2^n
    wire               grp_end  = take && (avg_cnt_ff >= need);                // this take closes a group
    reg  dec_valid_ff;
    reg  [`DATA_W-1:0] dec_data_ff;
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            avg_cnt_ff   <= 9'h000;
            acc_ff       <= {(`DATA_W+9){1'b0}};
            dec_valid_ff <= 1'b0;
            dec_data_ff  <= {`DATA_W{1'b0}};
        end
        else
        begin
            dec_valid_ff <= 1'b0;
            if (take)
            begin
                if (avg_cnt_ff >= need)
                begin
                    // last sample of the group: emit scaled mean
                    dec_valid_ff <= 1'b1;
                    dec_data_ff  <= grp_mean[`DATA_W-1:0];
                    avg_cnt_ff   <= 9'h000;
                    acc_ff       <= {(`DATA_W+9){1'b0}};
                end
                else
                begin
                    avg_cnt_ff <= avg_cnt_ff + 9'h001;
                    acc_ff     <= grp_sum;
                end
            end
        end
    end

    // optional fixed latency stage
    wire               dly_valid;
    wire [`DATA_W-1:0] dly_data;
    delay_line u_delay
    (
        .core_clk     (core_clk),
        .reset_n      (reset_n),
        .in_valid     (dec_valid_ff && delay_en),
        .in_data      (dec_data_ff),
        .out_valid_ff (dly_valid),
        .out_data_ff  (dly_data)
    );
    wire               pre_valid = delay_en ? dly_valid : dec_valid_ff;
    wire [`DATA_W-1:0] pre_data  = delay_en ? dly_data  : dec_data_ff;

    // two entry buffer; ready is registered and a taken word lands two cycles later,
    // so ready counts the closing take in flight as well, else a stall drops a word
    // limitation: the delay line holds up to 59 words, so a long stall with delay on can still drop
    wire pop = out_valid_ff && out_ready;
    wire       buf_wr      = pre_valid && (buf_cnt_ff != 2'h2);               // word enters buffer
    wire [1:0] nxt_buf_cnt = buf_cnt_ff + {1'b0, buf_wr} - {1'b0, pop};        // occupancy after this edge
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            buf_cnt_ff     <= 2'h0;
            buf_wp_ff      <= 1'b0;
            buf_rp_ff      <= 1'b0;
            buf_data_ff[0] <= {`DATA_W{1'b0}};
            buf_data_ff[1] <= {`DATA_W{1'b0}};
            out_valid_ff   <= 1'b0;
            out_data_ff    <= {`DATA_W{1'b0}};
            in_ready_ff    <= 1'b0;
        end
        else
        begin
            if (pre_valid && buf_cnt_ff != 2'h2)
            begin
                buf_data_ff[buf_wp_ff] <= pre_data;
                buf_wp_ff <= ~buf_wp_ff;
            end
            if (pop)
                buf_rp_ff <= ~buf_rp_ff;
            buf_cnt_ff <= nxt_buf_cnt;
            // present the head; after a pop the other entry becomes head
            if (pop)
            begin
                out_valid_ff <= (buf_cnt_ff == 2'h2) || pre_valid;
                out_data_ff  <= (buf_cnt_ff == 2'h2) ? buf_data_ff[~buf_rp_ff] : pre_data;
            end
            else if (!out_valid_ff && pre_valid)
            begin
                out_valid_ff <= 1'b1;
                out_data_ff  <= pre_data;
            end
            // trade-off: with no stages enabled the input takes two words in every three cycles
            in_ready_ff <= (nxt_buf_cnt == 2'h0) || ((nxt_buf_cnt == 2'h1) && !grp_end);
        end
    end
endmodule // decim_chain_a

/* File: decim_chain_a_monitor.sv */
// port-level assertion checker for the chain a decimator
`timescale 1ns/1ps
`include "decim_a_defs.vh"
module decim_chain_a_monitor
(
    // clock, reset and register port
    input wire               core_clk,
    input wire               reset_n,
    input wire [7:0]         reg_addr,
    input wire [7:0]         reg_wdata,
    input wire               reg_wr,
    input wire               reg_rd,
    input wire [7:0]         reg_rdata_ff,
    // mode, streams and status
    input wire [1:0]         chan_mode,
    input wire               in_valid,
    input wire [`DATA_W-1:0] in_data,
    input wire               in_ready_ff,
    input wire               out_valid_ff,
    input wire [`DATA_W-1:0] out_data_ff,
    input wire               out_ready,
    input wire [3:0]         stage_count_ff
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // read data is zero except in the answer cycle
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_ff == 8'h00)
        else $error("read data not zero outside answer cycle");
    unmapped_read_a: assert property (reg_rd && reg_addr != `REG_DUAL_PP && reg_addr != `REG_DELAY_FIRST // unmapped
        && reg_addr != `REG_CHAIN_A |=> reg_rdata_ff == 8'h00) else $error("unmapped read not zero");
    // factory bits must read back as written
    wr_rd_back_a: assert property (reg_wr && reg_addr == `REG_DELAY_FIRST ##1 !reg_wr ##1
        (reg_rd && reg_addr == `REG_DELAY_FIRST) |=> reg_rdata_ff == $past(reg_wdata, 3)) else $error("readback");
    stage_cap_a: assert property (stage_count_ff <= 4'h9) else $error("stage count above nine");
    // sync flops need a few cycles, hence six steady samples
    dual_cap_a: assert property ((chan_mode == `MODE_DUAL) [*6] |-> stage_count_ff <= 4'h8)
        else $error("dual stage count above eight");
    other_mode_a: assert property (chan_mode[1] [*6] |-> stage_count_ff == 4'h0)
        else $error("stages active outside single and dual");
    first_off_a: assert property ((chan_mode == `MODE_SINGLE) [*4] ##0 (reg_wr
        && reg_addr == `REG_DELAY_FIRST && !reg_wdata[`BIT_FIRST_EN]) |=> ##[0:1] stage_count_ff == 4'h0)
        else $error("first stage not off");
    out_hold_a: assert property (out_valid_ff && !out_ready |=> out_valid_ff && $stable(out_data_ff))
        else $error("output dropped under stall");
    stage_steady_a: assert property ((!reg_wr && $stable(chan_mode)) [*6] |=> $stable(stage_count_ff))
        else $error("stage count moved without cause");
endmodule // decim_chain_a_monitor
bind decim_chain_a decim_chain_a_monitor mon_u (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .chan_mode(chan_mode),
    .in_valid(in_valid), .in_data(in_data), .in_ready_ff(in_ready_ff), .out_valid_ff(out_valid_ff),
    .out_data_ff(out_data_ff), .out_ready(out_ready), .stage_count_ff(stage_count_ff));

/* File: decim_chain_a_tb_top.sv */
// self-checking bench for the chain a decimator
`timescale 1ns/1ps
`include "decim_a_defs.vh"
module decim_chain_a_tb_top;
    reg         core_clk, reset_n, reg_wr, reg_rd, in_valid, out_ready;
    reg  [7:0]  reg_addr, reg_wdata;
    reg  [1:0]  chan_mode;
    reg  [15:0] in_data;
    wire [7:0]  reg_rdata_ff;
    wire        in_ready_ff, out_valid_ff;
    wire [15:0] out_data_ff;
    wire [3:0]  stage_count_ff;
    integer     n_errors, checks, cyc, i, n, l0, l1;
    reg  [15:0] got_q [$]; // accepted output words
    decim_chain_a dut_u (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .chan_mode(chan_mode), .in_valid(in_valid),
        .in_data(in_data), .in_ready_ff(in_ready_ff), .out_valid_ff(out_valid_ff), .out_data_ff(out_data_ff),
        .out_ready(out_ready), .stage_count_ff(stage_count_ff));
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // collect words at the handshake edge, timeout guards hangs
    always @(posedge core_clk)
    begin
        if (out_valid_ff && out_ready)
            got_q.push_back(out_data_ff);
        cyc = cyc + 1;
        if (cyc == 5000)
        begin
            n_errors = n_errors + 1;
            summarize;
        end
    end
    task summarize;
    begin
        if (n_errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask
    task cmp(input string name, input [15:0] exp, input [15:0] got);
    begin
        checks = checks + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED %0s expected %h seen %h", name, exp, got);
        end
    end
    endtask
    task wr(input [7:0] a, input [7:0] d);
    begin
        @(posedge core_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    end
    endtask
    // read answer stands only in the cycle after the strobe
    task rd(input [7:0] a, input [7:0] e);
    begin
        @(posedge core_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 cmp("read data", {8'h00, e}, {8'h00, reg_rdata_ff});
    end
    endtask
    // nine-bit setting split over two registers, then let it settle
    task wset(input [8:0] s, input f);
    begin
        wr(`REG_DELAY_FIRST, {1'b0, s[0], f, 5'h00});
        wr(`REG_CHAIN_A, s[8:1]);
        repeat (5) @(posedge core_clk);
    end
    endtask
    task push(input [15:0] d);
    begin
        @(posedge core_clk);
        in_valid <= 1'b1; in_data <= d;
        @(posedge core_clk);
        while (in_ready_ff !== 1'b1) @(posedge core_clk);
        in_valid <= 1'b0;
    end
    endtask
    task lat(output integer l);
    begin
        push(16'h0000);
        l = 0;
        while (out_valid_ff !== 1'b1)
        begin
            @(posedge core_clk);
            l = l + 1;
        end
    end
    endtask
    initial
    begin
        {reset_n, reg_wr, reg_rd, in_valid, out_ready} = 5'h00;
        reg_addr = 8'h00; reg_wdata = 8'h00; chan_mode = `MODE_SINGLE; in_data = 16'h0000;
        n_errors = 0; checks = 0; cyc = 0;
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1; out_ready <= 1'b1;
        rd(`REG_DELAY_FIRST, `RST_DELAY_FIRST);
        rd(`REG_CHAIN_A, `RST_CHAIN_A); rd(`REG_DUAL_PP, `RST_DUAL_PP);
        wr(8'h55, 8'hFF); rd(8'h55, 8'h00);
        wr(`REG_DELAY_FIRST, 8'h60); rd(`REG_DELAY_FIRST, 8'h60);
        repeat (3) @(posedge core_clk);
        cmp("stage count", 16'h0001, stage_count_ff);
        for (i = 0; i < 10; i = i + 1)
        begin
            wset((9'h001 << i) - 9'h001, 1'b0);
            cmp("stage count", i, stage_count_ff);
        end
        wset(9'h005, 1'b0); cmp("stage count", 16'h0001, stage_count_ff);
        wset(9'h003, 1'b0); got_q.delete();
        wr(8'h02, 8'h02); rd(8'h02, 8'h00);
        push(16'h000A); push(16'h0014); push(16'h001E); push(16'h0028);
        for (i = 0; i < 4; i = i + 1) push(16'h0100);
        repeat (5) @(posedge core_clk);
        cmp("output count", 16'h0002, got_q.size());
        cmp("group mean", 16'h0019, got_q[0]); cmp("group mean", 16'h0100, got_q[1]);
        chan_mode <= `MODE_DUAL; wset(9'h1FE, 1'b0);
        cmp("stage count", 16'h0000, stage_count_ff);
        wr(`REG_DUAL_PP, 8'h80); repeat (3) @(posedge core_clk);
        cmp("stage count", 16'h0008, stage_count_ff);
        wset(9'h007, 1'b0); cmp("stage count", 16'h0002, stage_count_ff);
        chan_mode <= 2'h2; repeat (6) @(posedge core_clk);
        cmp("stage count", 16'h0000, stage_count_ff);
        chan_mode <= `MODE_SINGLE; wset(9'h000, 1'b0); lat(l0);
        wset(9'h000, 1'b1); lat(l1);
        cmp("added latency", `DELAY_REC_CYCLES, l1 - l0);
        wset(9'h000, 1'b0); got_q.delete();
        // stall the receiver until the input is refused, then drain
        out_ready <= 1'b0; n = 0;
        @(posedge core_clk);
        in_valid <= 1'b1; in_data <= 16'h0000;
        repeat (10)
        begin
            @(posedge core_clk);
            if (in_ready_ff === 1'b1)
            begin
                n = n + 1;
                in_data <= n;
            end
        end
        cmp("ready under stall", 16'h0000, in_ready_ff);
        in_valid <= 1'b0; out_ready <= 1'b1;
        repeat (10) @(posedge core_clk);
        cmp("drained words", n, got_q.size());
        for (i = 0; i < n; i = i + 1) cmp("drained word", i, got_q[i]);
        summarize;
    end
endmodule // decim_chain_a_tb_top

/* File: delay_line.v */
// fixed-length delay memory for the fractional delay recovery path
`timescale 1ns/1ps
`include "decim_a_defs.vh"
module delay_line
(
    // clock and reset
    input  wire                 core_clk,
    input  wire                 reset_n,
    // sample in
    input  wire                 in_valid,
    input  wire [`DATA_W-1:0]   in_data,
    // delayed sample out, registered
    output reg                  out_valid_ff,
    output reg  [`DATA_W-1:0]   out_data_ff
);
    reg [`DATA_W-1:0] mem_ff [0:`DELAY_REC_CYCLES-2];  // shift memory
    reg [`DELAY_REC_CYCLES-2:0] vld_ff;                 // valid shadow
    integer i;

    // shift every clock so the added latency is exactly the cycle count
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            vld_ff       <= {(`DELAY_REC_CYCLES-1){1'b0}};
            out_valid_ff <= 1'b0;
            out_data_ff  <= {`DATA_W{1'b0}};
        end
        else
        begin
            vld_ff       <= {vld_ff[`DELAY_REC_CYCLES-3:0], in_valid};
            out_valid_ff <= vld_ff[`DELAY_REC_CYCLES-2];
            out_data_ff  <= mem_ff[`DELAY_REC_CYCLES-2];
        end
    end

    // data memory carries no reset, only the valid shadow matters
    always @(posedge core_clk)
    begin
        mem_ff[0] <= in_data;
        for (i = 1; i < `DELAY_REC_CYCLES-1; i = i + 1)
            mem_ff[i] <= mem_ff[i-1];
    end
endmodule // delay_line
